// File: design/chan_drive_if.sv
// Purpose: carries ms tick and per-channel brightness between modules
// Assumes: one pclk domain
// Notes:   level 15 means fully on
`timescale 1ns/10ps

interface chan_drive_if;
   import led_seq_pkg::*;
   logic                         tick;
   logic [NUM_CHAN-1:0][LVL_W-1:0] level;
   logic [NUM_CHAN-1:0]          fast;

   modport timebase (output tick);
   modport seq      (input tick, output level, output fast);
   modport pwm      (input level, input fast);
endinterface : chan_drive_if

// File: design/led_behavior_sequencer.sv
// Purpose: eight-channel led behaviour sequencer with apb registers
// Assumes: touch inputs are asynchronous levels; apb master on pclk
// Notes:   led_on is active high; polarity is handled outside
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps

module led_behavior_sequencer
   import led_seq_pkg::*;
#(
   parameter int unsigned TICKS_PER_MS = TICK_CYCLES
) (
   // clock and reset
   input  wire logic                pclk,
   input  wire logic                presetn,
   // apb slave
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [11:0]         paddr,
   input  wire logic [31:0]         pwdata,
   output logic                     pready,
   output logic [31:0]              prdata,
   output logic                     pslverr,
   // touch sensing
   input  wire logic [NUM_CHAN-1:0] touch,
   // led drive
   output logic [NUM_CHAN-1:0]      led_on
);
   import led_seq_pkg::*;

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0]          behav_low;
   logic [7:0]          behav_high;
   logic [15:0]         behav_all;
   logic [7:0]          p1_period;
   logic [PER_W-1:0]    p2_period;
   logic [PER_W-1:0]    br_period;
   logic [5:0]          led_config;
   logic [7:0]          host_drive_bit;
   logic [7:0]          link_en;
   logic [7:0]          duty;
   logic [NUM_CHAN-1:0] active;
   logic [NUM_CHAN-1:0] touch_meta;
   logic [NUM_CHAN-1:0] touch_sync;
   logic [7:0]          index;
   logic                setup;
   logic                wr_en;
   logic                known;
   logic [31:0]         rd_word;

   chan_drive_if drv ();

   assign index = paddr[9:2];
   assign behav_all = {behav_high, behav_low};
   assign setup = psel & ~penable;
   // refused addresses must never alias onto a mapped register
   assign wr_en = psel & penable & pready & pwrite & known;
   assign known = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
                  (index inside {IDX_BEHAV_LOW, IDX_BEHAV_HIGH, IDX_P1_PERIOD,
                                 IDX_P2_PERIOD, IDX_BR_PERIOD, IDX_CONFIG,
                                 IDX_HOST_DRIVE, IDX_LINK, IDX_DUTY,
                                 IDX_ACTIVE, IDX_TOUCH});

   // ---------------------------------------------------------------
   // apb handshake: answer one cycle after setup, no wait states
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~known;
         prdata  <= (setup && !pwrite && known) ? rd_word : 32'h0000_0000;
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (index)
         IDX_BEHAV_LOW:  rd_word[7:0] = behav_low;
         IDX_BEHAV_HIGH: rd_word[7:0] = behav_high;
         IDX_P1_PERIOD:  rd_word[7:0] = p1_period;
         IDX_P2_PERIOD:  rd_word[7:0] = {1'b0, p2_period};
         IDX_BR_PERIOD:  rd_word[7:0] = {1'b0, br_period};
         IDX_CONFIG:     rd_word[7:0] = {2'h0, led_config};
         IDX_HOST_DRIVE: rd_word[7:0] = host_drive_bit;
         IDX_LINK:       rd_word[7:0] = link_en;
         IDX_DUTY:       rd_word[7:0] = duty;
         IDX_ACTIVE:     rd_word[7:0] = active;
         IDX_TOUCH:      rd_word[7:0] = touch_sync;
         default:        rd_word      = 32'h0000_0000;
      endcase
   end

   // ---------------------------------------------------------------
   // register writes
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         behav_low      <= RST_BEHAV;
         behav_high     <= RST_BEHAV;
         p1_period      <= RST_P1_PERIOD; // RULE14
         p2_period      <= RST_P2_PERIOD[PER_W-1:0]; // RULE18
         br_period      <= RST_BR_PERIOD[PER_W-1:0]; // RULE19
         led_config     <= RST_CONFIG[5:0]; // RULE20
         host_drive_bit <= RST_ZERO;
         link_en        <= RST_ZERO;
         duty           <= RST_DUTY;
      end else if (wr_en) begin
         unique case (index)
            IDX_BEHAV_LOW:  behav_low      <= pwdata[7:0]; // RULE7
            IDX_BEHAV_HIGH: behav_high     <= pwdata[7:0]; // RULE7
            IDX_P1_PERIOD:  p1_period      <= pwdata[7:0]; // RULE10
            IDX_P2_PERIOD:  p2_period      <= pwdata[PER_W-1:0];
            IDX_BR_PERIOD:  br_period      <= pwdata[PER_W-1:0];
            IDX_CONFIG:     led_config     <= pwdata[5:0];
            IDX_HOST_DRIVE: host_drive_bit <= pwdata[7:0];
            IDX_LINK:       link_en        <= pwdata[7:0];
            IDX_DUTY:       duty           <= pwdata[7:0];
            default:        ;
         endcase
      end
   end

   // ---------------------------------------------------------------
   // touch synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         touch_meta <= 8'h00;
         touch_sync <= 8'h00;
      end else begin
         touch_meta <= touch;
         touch_sync <= touch_meta;
      end
   end

   // ---------------------------------------------------------------
   // time base and pwm
   // ---------------------------------------------------------------
   ms_timebase #(
      .TICKS   (TICKS_PER_MS)
   ) u_timebase (
      .pclk    (pclk),
      .presetn (presetn),
      .tb      (drv)
   );

   led_pwm_out u_pwm (
      .pclk    (pclk),
      .presetn (presetn),
      .drv     (drv),
      .led_on  (led_on)
   );

   // ---------------------------------------------------------------
   // per-channel sequencer
   // ---------------------------------------------------------------
   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_seq
      behavior_t          sel;
      seq_state_t         state;
      logic               src;
      logic               src_prev;
      logic               rise;
      logic               fall;
      logic               start_evt;
      logic               stopping;
      logic [3:0]         left;
      logic [HALF_W-1:0]  half_q;
      logic [HALF_W-1:0]  pos;
      logic [HALF_W-1:0]  acc;
      logic [HALF_W-1:0]  acc_sum;
      logic [LVL_W-1:0]   min_q;
      logic [LVL_W-1:0]   max_q;
      logic [LVL_W-1:0]   span;
      logic [LVL_W-1:0]   level;
      logic [HALF_W-1:0]  next_half;
      logic               ramp_end;

      assign sel = behavior_t'(behav_all[2*g +: 2]); // RULE7
      // a linked channel follows its sensor, else the host drive bit
      assign src = link_en[g] ? touch_sync[g] : host_drive_bit[g]; // RULE17
      // a source swap shows up as a level change: a missing touch or a
      // low drive bit is seen as a release
      assign rise = src & ~src_prev; // RULE4
      assign fall = ~src & src_prev; // RULE5 RULE6
      assign start_evt = p1_period[P1_TRIG_BIT] ? fall : rise; // RULE10
      assign span = (max_q > min_q) ? max_q - min_q : 4'h0;
      assign acc_sum = acc + HALF_W'(span);
      assign ramp_end = (pos == half_q - 11'h001);

      always_comb begin
         unique case (sel)
            BEH_PULSE_ONE: next_half = half_ms(p1_period[PER_W-1:0]); // RULE13
            BEH_PULSE_TWO: next_half = half_ms(p2_period); // RULE13
            default:       next_half = half_ms(br_period); // RULE12
         endcase
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) src_prev <= 1'b0;
         else          src_prev <= src;
      end

      // settings are taken once per actuation, so edits made while
      // breathing wait for the next start
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            half_q <= 11'h010;
            min_q  <= 4'h0;
            max_q  <= 4'hF;
         end else if (state == ST_IDLE || state == ST_ON) begin // RULE1
            half_q <= next_half;
            min_q  <= duty[DUTY_MIN_LSB +: LVL_W];
            max_q  <= duty[DUTY_MAX_LSB +: LVL_W];
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            state    <= ST_IDLE;
            stopping <= 1'b0;
            left     <= 4'h0;
            pos      <= 11'h000;
            acc      <= 11'h000;
            level    <= 4'h0;
         end else if (sel == BEH_DIRECT) begin
            state    <= src ? ST_ON : ST_IDLE; // RULE8 RULE3
            stopping <= 1'b0;
            pos      <= 11'h000;
            acc      <= 11'h000;
            level    <= duty[DUTY_MIN_LSB +: LVL_W];
         end else if (state == ST_ON ||
                      (state == ST_IDLE &&
                       ((sel == BEH_PULSE_ONE) ? start_evt : rise))) begin // RULE3 RULE2
            state    <= ST_UP;
            stopping <= 1'b0;
            left     <= {1'b0, led_config[CNT1_LSB +: CNT_W]} + 4'h1; // RULE20 RULE9
            pos      <= 11'h000;
            acc      <= 11'h000;
            level    <= duty[DUTY_MIN_LSB +: LVL_W];
         end else if (state == ST_IDLE) begin
            level    <= duty[DUTY_MIN_LSB +: LVL_W];
         end else if (sel == BEH_BREATHE && fall) begin
            state    <= ST_IDLE; // RULE12 RULE4
         end else if (sel == BEH_PULSE_TWO && fall && !stopping) begin
            stopping <= 1'b1; // RULE11
            left     <= {1'b0, led_config[CNT2_LSB +: CNT_W]} + 4'h1; // RULE20
         end else if (drv.tick) begin // RULE21
            // one level step per ms at most; each half period still ends
            // after half_q ticks, where the level is set to max_q or min_q
            if (ramp_end) begin // RULE15
               pos <= 11'h000;
               acc <= 11'h000;
               if (state == ST_UP) begin
                  state <= ST_DOWN;
                  level <= max_q;
               end else begin
                  level <= min_q;
                  if ((sel == BEH_PULSE_ONE || stopping) && left <= 4'h1)
                     state <= ST_IDLE; // RULE9 RULE11
                  else begin
                     state <= ST_UP;
                     if (sel == BEH_PULSE_ONE || stopping)
                        left <= left - 4'h1;
                  end
               end
            end else begin
               pos <= pos + 11'h001;
               if (acc_sum >= half_q) begin // RULE12
                  acc <= acc_sum - half_q;
                  if (state == ST_UP && level < max_q)
                     level <= level + 4'h1;
                  else if (state == ST_DOWN && level > min_q)
                     level <= level - 4'h1;
               end else begin
                  acc <= acc_sum;
               end
            end
         end
      end

      // drive level: direct follows the duty register live
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            drv.level[g] <= 4'h0;
            drv.fast[g]  <= 1'b1;
            active[g]    <= 1'b0;
         end else begin
            drv.level[g] <= (state == ST_ON) ? duty[DUTY_MAX_LSB +: LVL_W] : level;
            drv.fast[g]  <= (sel == BEH_DIRECT); // RULE16
            active[g]    <= (state != ST_IDLE);
         end
      end
   end

endmodule : led_behavior_sequencer

// File: design/led_pwm_out.sv
// Purpose: sixteen-step pwm per channel from brightness level
// Assumes: level 15 is always on
// Notes:   ramping channels run a slower pwm to keep ramp steps clean
`timescale 1ns/10ps

module led_pwm_out
   import led_seq_pkg::*;
(
   input  wire logic                pclk,
   input  wire logic                presetn,
   chan_drive_if.pwm                drv,
   output logic [NUM_CHAN-1:0]      led_on
);
   logic [1:0]                     prescale;
   logic [NUM_CHAN-1:0][LVL_W-1:0] phase;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prescale <= 2'h0;
      else          prescale <= prescale + 2'h1;
   end

   for (genvar g = 0; g < NUM_CHAN; g++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            phase[g]  <= 4'h0;
            led_on[g] <= 1'b0;
         end else begin
            if (drv.fast[g] || prescale == SLOW_PRESCALE) // RULE16
               phase[g] <= phase[g] + 4'h1;
            led_on[g] <= (phase[g] < drv.level[g]) || (drv.level[g] == 4'hF);
         end
      end
   end
endmodule : led_pwm_out

// File: design/led_seq_pkg.sv
// Purpose: shared constants and types for the led behaviour sequencer
// Assumes: apb word registers, 25 MHz pclk, 1 ms time base
// Notes:   register indices are byte address divided by four
//
// Function
// [RULE1] ramp settings latched at start, held until re-actuation
// [RULE2] pulse one ignores drive bit until finished
// [RULE3] behaviour select change acts on channel at once
// [RULE4] link switch: direct/breathe follow, pulses finish
// [RULE5] unlinked with drive bit low acts as release
// [RULE6] linked without touch acts as release
// [RULE7] two-bit select per channel, two registers
// [RULE8] direct: active on touch/set, inactive on release/clear
// [RULE9] pulse one: counted min-max-min pulses, no stop
// [RULE10] start-trigger bit picks touch or release start
// [RULE11] pulse two: pulse until stop, then counted pulses
// [RULE12] breathe: min to max and back, half period each
// [RULE13] seven-bit period, 32 ms steps, zero equals one
// [RULE14] pulse one period register resets to 1024 ms
// [RULE15] short periods run as fast as ramp allows
// [RULE16] pwm rate from behaviour; direct uses maximum rate
// [RULE17] unlinked drive bit set/cleared is touch/release
// [RULE18] pulse two period resets to 640 ms
// [RULE19] breathe period resets to 2976 ms
// [RULE20] pulse count code n gives n+1 pulses
// [RULE21] millisecond time base times all channels

package led_seq_pkg;

   // ---------------------------------------------------------------
   // register indices
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_BEHAV_LOW  = 8'h81;
   localparam logic [7:0] IDX_BEHAV_HIGH = 8'h82;
   localparam logic [7:0] IDX_P1_PERIOD  = 8'h84;
   localparam logic [7:0] IDX_P2_PERIOD  = 8'h85;
   localparam logic [7:0] IDX_BR_PERIOD  = 8'h86;
   localparam logic [7:0] IDX_CONFIG     = 8'h88;
   localparam logic [7:0] IDX_HOST_DRIVE = 8'h8A;
   localparam logic [7:0] IDX_LINK       = 8'h8B;
   localparam logic [7:0] IDX_DUTY       = 8'h8C;
   localparam logic [7:0] IDX_ACTIVE     = 8'h8D;
   localparam logic [7:0] IDX_TOUCH      = 8'h8E;

   // ---------------------------------------------------------------
   // reset values and fields
   // ---------------------------------------------------------------
   localparam logic [7:0] RST_BEHAV     = 8'h00;
   localparam logic [7:0] RST_P1_PERIOD = 8'h20;
   localparam logic [7:0] RST_P2_PERIOD = 8'h14;
   localparam logic [7:0] RST_BR_PERIOD = 8'h5D;
   localparam logic [7:0] RST_CONFIG    = 8'h04;
   localparam logic [7:0] RST_DUTY      = 8'hF0;
   localparam logic [7:0] RST_ZERO      = 8'h00;
   localparam int         P1_TRIG_BIT   = 7;
   localparam int         PER_W         = 7;
   localparam int         CNT1_LSB      = 0;
   localparam int         CNT2_LSB      = 3;
   localparam int         CNT_W         = 3;
   localparam int         DUTY_MIN_LSB  = 0;
   localparam int         DUTY_MAX_LSB  = 4;
   localparam int         LVL_W         = 4;
   localparam int         NUM_CHAN      = 8;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int unsigned CLK_HZ         = 25_000_000;
   localparam int unsigned TIME_BASE_MS   = 1;
   localparam int unsigned TICK_CYCLES    = CLK_HZ / 1000 * TIME_BASE_MS;
   localparam int unsigned PERIOD_STEP_MS = 32;
   localparam int unsigned HALF_STEP_MS   = PERIOD_STEP_MS / 2;
   localparam int          HALF_W         = 11;
   localparam logic [1:0]  SLOW_PRESCALE  = 2'h3;

   typedef enum logic [1:0] {
      BEH_DIRECT    = 2'h0,
      BEH_PULSE_ONE = 2'h1,
      BEH_PULSE_TWO = 2'h2,
      BEH_BREATHE   = 2'h3
   } behavior_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_ON   = 4'h2,
      ST_UP   = 4'h4,
      ST_DOWN = 4'h8
   } seq_state_t;

   // half of a period in ms; settings 0 and 1 both mean one step
   function automatic logic [HALF_W-1:0] half_ms(input logic [PER_W-1:0] field);
      logic [PER_W-1:0] eff;
      eff     = (field == 7'h00) ? 7'h01 : field;
      half_ms = HALF_W'(eff * HALF_STEP_MS);
   endfunction : half_ms

endpackage : led_seq_pkg

// File: design/ms_timebase.sv
// Purpose: one-cycle tick every millisecond
// Assumes: pclk at the package clock rate
// Notes:   TICKS is shortened in simulation
`timescale 1ns/10ps

module ms_timebase #(
   parameter int unsigned TICKS = 25000
) (
   input  wire logic    pclk,
   input  wire logic    presetn,
   chan_drive_if.timebase tb
);
   logic [15:0] count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count   <= 16'h0000;
         tb.tick <= 1'b0;
      end else if (count == 16'(TICKS - 1)) begin // RULE21
         count   <= 16'h0000;
         tb.tick <= 1'b1;
      end else begin
         count   <= count + 16'h0001;
         tb.tick <= 1'b0;
      end
   end
endmodule : ms_timebase

// File: verif/led_behavior_sequencer_assertions.sv
// Purpose: port checker for the led behaviour sequencer
// Assumes: one pclk domain, apb answer in the cycle after setup
// Notes:   bound from the bench top file
`timescale 1ns/10ps

module led_seq_checker (
   // clock and reset
   input wire logic                           pclk,
   input wire logic                           presetn,
   // apb
   input wire logic                           psel,
   input wire logic                           penable,
   input wire logic                           pwrite,
   input wire logic [11:0]                    paddr,
   input wire logic [31:0]                    pwdata,
   input wire logic                           pready,
   input wire logic [31:0]                    prdata,
   input wire logic                           pslverr,
   // pads and leds
   input wire logic [led_seq_pkg::NUM_CHAN-1:0] touch,
   input wire logic [led_seq_pkg::NUM_CHAN-1:0] led_on
);
   import led_seq_pkg::*;
   logic wrote;

   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   // nothing can light a led before software has written a register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrote <= 1'b0;
      end else if (psel && penable && pwrite && pready) begin
         wrote <= 1'b1;
      end
   end

   ready_after_setup_a: assert property (psel && !penable |=> pready)
      else $error("no ready after setup");
   ready_in_access_a: assert property (pready |-> psel && penable)
      else $error("ready outside access");
   ready_one_cycle_a: assert property (pready |=> !pready)
      else $error("ready held too long");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   err_rdata_zero_a: assert property (pslverr |-> prdata == 32'h0)
      else $error("refused read returned data");
   rdata_idle_zero_a: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside access");
   rdata_upper_zero_a: assert property (prdata[31:8] == 24'h0)
      else $error("upper read data not zero");
   unmapped_err_a: assert property (psel && !penable && paddr[9:2] < 8'h81 |=> pslverr)
      else $error("unmapped access not refused");
   mapped_no_err_a: assert property (psel && !penable && paddr == 12'h204 |=> !pslverr)
      else $error("mapped access refused");
   leds_dark_a: assert property (!wrote |-> led_on == 8'h00)
      else $error("led lit before any write");

   write_cov: cover property (psel && penable && pwrite && pready);
   err_cov: cover property (pslverr);
   lit_cov: cover property (led_on != 8'h00);
endmodule : led_seq_checker

// File: verif/led_touch_model.sv
// Purpose: touch pads and led loads on the far side of the sequencer
// Assumes: a pad follows its press request one clock later
// Notes:   on_cnt counts lit clocks per channel and wraps freely
`timescale 1ns/10ps

module led_touch_model
   import led_seq_pkg::*;
(
   // clock
   input  wire logic                 pclk,
   // pads and loads
   input  wire logic [NUM_CHAN-1:0]  press,
   input  wire logic [NUM_CHAN-1:0]  led_on,
   output logic [NUM_CHAN-1:0]       touch,
   output logic [NUM_CHAN-1:0][15:0] on_cnt
);
   initial begin
      touch  = '0;
      on_cnt = '0;
   end

   // pads hold their level; no bounce is modelled
   always @(posedge pclk) begin
      touch <= press;
      for (int g = 0; g < NUM_CHAN; g++) begin
         on_cnt[g] <= on_cnt[g] + 16'(led_on[g]);
      end
   end
endmodule : led_touch_model

// File: verif/test_led_behavior_sequencer.sv
// Purpose: self-checking bench for the led behaviour sequencer
// Assumes: TICKS_PER_MS shortened to 8, so one ms is 8 clocks
// Notes:   a register shadow predicts every rchk read; activity reads are checked against given values
`timescale 1ns/10ps

module test_led_behavior_sequencer;
   import led_seq_pkg::*;
   localparam int MS = 8;
   logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0]               paddr;
   logic [31:0]               pwdata, prdata, rd, rng;
   logic [NUM_CHAN-1:0]       touch, press, led_on;
   logic [NUM_CHAN-1:0][15:0] on_cnt;
   logic [7:0]                shadow [int];
   int                        n_mismatch, compares;

   led_behavior_sequencer #(.TICKS_PER_MS(MS)) DUT (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr), .touch(touch), .led_on(led_on));
   led_touch_model pads (.pclk(pclk), .press(press), .led_on(led_on), .touch(touch),
      .on_cnt(on_cnt));

   always #20 pclk = ~pclk;

   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs

   task summarize;
      if (n_mismatch == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer; waits for pready under a bound
   task apb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= {2'h0, idx, 2'h0};
      pwdata  <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         n_mismatch++;
         summarize();
      end
   endtask : apb

   task wr(input logic [7:0] idx, input logic [7:0] d);
      apb(1'b1, idx, d);
      if (shadow.exists(idx)) shadow[idx] = d;
   endtask : wr

   task rchk(input logic [7:0] idx);
      apb(1'b0, idx, 8'h00);
      chk(rd, shadow.exists(idx) ? {24'h0, shadow[idx]} : 32'h0);
      chk({31'h0, err}, {31'h0, !shadow.exists(idx)});
   endtask : rchk

   task ms(input int n);
      repeat (n * MS) @(posedge pclk);
   endtask : ms

   task act(input logic [7:0] e);
      ms(1);
      apb(1'b0, IDX_ACTIVE, 8'h00);
      chk(rd, {24'h0, e});
   endtask : act

   // lit clocks of one channel over 32 clocks, after the level settles
   task lit(input int ch, input logic [15:0] e);
      logic [15:0] c0;
      ms(2);
      c0 = on_cnt[ch];
      repeat (32) @(posedge pclk);
      chk(32'(on_cnt[ch] - c0), 32'(e));
   endtask : lit

   initial begin
      {pclk, presetn, psel, penable, pwrite, paddr, pwdata, press} = '0;
      rng = 32'h13005D58;
      n_mismatch = 0;
      compares = 0;
      shadow = '{8'h81:8'h00, 8'h82:8'h00, 8'h84:8'h20, 8'h85:8'h14, 8'h86:8'h5D,
                 8'h88:8'h04, 8'h8A:8'h00, 8'h8B:8'h00, 8'h8C:8'hF0};
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      foreach (shadow[i]) rchk(i[7:0]);
      rchk(8'h10);
      repeat (4) begin
         rng = xs(rng);
         wr(8'h81, rng[7:0]);
         rchk(8'h81);
         wr(8'h82, rng[15:8]);
         rchk(8'h82);
         wr(8'h84, rng[23:16]);
         rchk(8'h84);
      end
      wr(8'h81, 8'h00);
      wr(8'h82, 8'h00);
      wr(8'h84, 8'h01);
      wr(8'h85, 8'h01);
      wr(8'h86, 8'h01);
      wr(8'h88, 8'h01);
      wr(IDX_ACTIVE, 8'hFF);
      act(8'h00);
      // direct, host driven then linked
      wr(8'h8A, 8'h01);
      lit(0, 32);
      act(8'h01);
      wr(8'h8B, 8'h01);
      lit(0, 0);
      press <= 8'h01;
      lit(0, 32);
      wr(8'h8A, 8'h00);
      lit(0, 32);
      wr(8'h8B, 8'h00);
      lit(0, 0);
      press <= 8'h00;
      // breathe on channel 1
      wr(8'h81, 8'h0C);
      wr(8'h8A, 8'h02);
      act(8'h02);
      ms(8);
      act(8'h02);
      wr(8'h8A, 8'h00);
      act(8'h00);
      // pulse one, two pulses of 32 ms; a clear and set is forgotten
      wr(8'h81, 8'h10);
      wr(8'h8A, 8'h04);
      ms(8);
      wr(8'h8A, 8'h00);
      wr(8'h8A, 8'h04);
      ms(35);
      act(8'h04);
      ms(35);
      act(8'h00);
      wr(8'h84, 8'h81);
      wr(8'h8A, 8'h00);
      act(8'h04);
      ms(70);
      act(8'h00);
      // pulse two, then a behaviour change while running
      wr(8'h81, 8'h80);
      wr(8'h8A, 8'h08);
      ms(40);
      act(8'h08);
      wr(8'h81, 8'h00);
      lit(3, 32);
      wr(8'h8C, 8'h80);
      lit(3, 16);
      wr(8'h8C, 8'hF0);
      wr(8'h81, 8'h80);
      act(8'h08);
      wr(8'h8A, 8'h00);
      act(8'h08);
      ms(40);
      act(8'h00);
      summarize();
   end
endmodule : test_led_behavior_sequencer

bind led_behavior_sequencer led_seq_checker chk (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .prdata(prdata), .pslverr(pslverr), .touch(touch), .led_on(led_on));
